// *** hw/fpc_params.svh ***
// register map, field positions, limits and fault codes of the counter control block
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_ADDR_W 6
`define FPC_OFS_CTRL 6'h00
`define FPC_OFS_SUBSEL 6'h04
`define FPC_OFS_FAULT 6'h08
`define FPC_OFS_MODE 6'h0c
`define FPC_OFS_HIGH 6'h10
`define FPC_OFS_LOW 6'h14
`define FPC_OFS_OVF 6'h18
`define FPC_OFS_CALLS 6'h1c

`define FPC_CTRL_FN_ON 0
`define FPC_CTRL_AUTOSTART 1
`define FPC_CTRL_COUNT_GATE 2
`define FPC_CTRL_LOAD 3
`define FPC_CTRL_SUB_GATE 4
`define FPC_CTRL_FAULT 5
`define FPC_CTRL_RUN 6
`define FPC_CTRL_COUNTING 7

`define FPC_FILE_MIN 16'h0003
`define FPC_FILE_MAX 16'h00ff
`define FPC_MODE_MAX 16'h0007
`define FPC_MODE_SPLIT 16'h0002

`define FPC_ERR_NONE 16'h0000
`define FPC_ERR_FILE 16'h0001
`define FPC_ERR_MODE 16'h0002
`define FPC_ERR_HIGH 16'h0003
`define FPC_ERR_OVF 16'h0004

`endif

// *** hw/fpc_pkg.sv ***
// shared types of the counter control block
package fpc_pkg;
    typedef logic [15:0] fpc_word_t;
    typedef struct packed {
        logic unf;
        logic ovf;
        logic hi;
        logic lo;
    } fpc_cause_t;
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} fpc_bus_state_t;
endpackage

// *** hw/fpc_cfg_if.sv ***
// configuration candidate and its fault verdict between control and checker
`timescale 1ns/10ps
`default_nettype none
interface fpc_cfg_if #(parameter int CNT_W = 32);
    import fpc_pkg::*;
    fpc_word_t selector;
    logic file_present;
    fpc_word_t mode;
    logic signed [CNT_W-1:0] high;
    logic signed [CNT_W-1:0] low;
    logic signed [CNT_W-1:0] ovf;
    fpc_word_t fault;
    modport ctl (output selector, file_present, mode, high, low, ovf, input fault);
    modport chk (input selector, file_present, mode, high, low, ovf, output fault);
endinterface
`default_nettype wire

// *** hw/fpc_cfg_check.sv ***
// configuration checker: returns the fault code for a candidate setting
`timescale 1ns/10ps
`default_nettype none
`include "fpc_params.svh"
module fpc_cfg_check #(
    parameter int CNT_W = 32
) (
    fpc_cfg_if.chk cfg
);
    import fpc_pkg::*;

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("fpc_cfg_check: CNT_W out of range");
        end
    end

    function automatic logic in_range(input fpc_word_t v, input fpc_word_t lo, input fpc_word_t hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // first failing check wins, in fault code order
    always_comb begin
        if (!cfg.file_present || !in_range(cfg.selector, `FPC_FILE_MIN, `FPC_FILE_MAX)) begin
            cfg.fault = `FPC_ERR_FILE;
        end else if (!in_range(cfg.mode, 16'h0000, `FPC_MODE_MAX)) begin
            cfg.fault = `FPC_ERR_MODE;
        end else if (cfg.mode < `FPC_MODE_SPLIT && cfg.high <= 0) begin
            cfg.fault = `FPC_ERR_HIGH;
        end else if (cfg.mode >= `FPC_MODE_SPLIT && cfg.high <= cfg.low) begin
            cfg.fault = `FPC_ERR_HIGH;
        end else if (cfg.high > cfg.ovf) begin
            cfg.fault = `FPC_ERR_OVF;
        end else begin
            cfg.fault = `FPC_ERR_NONE;
        end
    end
endmodule // fpc_cfg_check
`default_nettype wire

// *** hw/fpc_sub_dispatch.sv ***
// subroutine call dispatcher: turns counter events into one call request
`timescale 1ns/10ps
`default_nettype none
module fpc_sub_dispatch (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire fpc_pkg::fpc_cause_t cause_in,
    input wire logic allow_in,
    input wire fpc_pkg::fpc_word_t file_in,
    output logic call_req_out,
    output fpc_pkg::fpc_word_t call_file_out,
    output fpc_pkg::fpc_cause_t call_cause_out
);
    import fpc_pkg::*;

    logic hit;

    assign hit = |cause_in;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            call_req_out <= 1'b0;
        end else begin
            call_req_out <= hit && allow_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            call_file_out <= 16'h0000;
            call_cause_out <= '0;
        end else if (hit && allow_in) begin
            call_file_out <= file_in;
            call_cause_out <= cause_in;
        end
    end
endmodule // fpc_sub_dispatch
`default_nettype wire

// *** hw/fpc_ctrl_status.sv ***
// control and status registers of the fast pulse counter
// How it works
// - preset or limit event calls the subroutine named by the selector
// - selector valid only for an existing file 3 to 255
// - fault code 1 for a bad file, code 2 for a bad mode
// - modes 0 and 1: fault code 3 when high preset not positive
// - modes 2 to 7: fault code 3 when high not above low
// - any mode: fault code 4 when high preset exceeds overflow limit
// - fault-present flag is read-only and follows any configuration fault
// - function-on bit gates counter subroutine calls
// - function-on is writable and set by hardware on auto start
// - auto start starts the function on every run or test entry
// - auto start comes from stored configuration, read-only to software
// - auto start alone never enables counting; count gate also needed
// - counting only while count gate is 1; gate restored from the backup store after reset
// - clearing count gate freezes the count; setting resumes from it
// - count gate written by software and kept over power cycles
// - rising edge of load-settings checks, loads, then uses new settings
// - load-settings kept over power cycles; toggling it stops counting only when the new settings are faulty
// - subroutine gate covers low, high, overflow and underflow events
// - subroutine gate at 0 means no automatic subroutine call
`timescale 1ns/10ps
`default_nettype none
`include "fpc_params.svh"
module fpc_ctrl_status #(
    parameter int CNT_W = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [`FPC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic run_mode_in,
    input wire fpc_pkg::fpc_word_t cfg_selector_in,
    input wire logic cfg_file_present_in,
    input wire logic cfg_autostart_in,
    input wire fpc_pkg::fpc_word_t cfg_mode_in,
    input wire logic signed [CNT_W-1:0] cfg_high_in,
    input wire logic signed [CNT_W-1:0] cfg_low_in,
    input wire logic signed [CNT_W-1:0] cfg_ovf_in,
    input wire logic ret_count_gate_in,
    input wire logic ret_load_settings_in,
    input wire logic lo_preset_hit_in,
    input wire logic hi_preset_hit_in,
    input wire logic ovf_pass_in,
    input wire logic unf_pass_in,
    output logic count_enable_out,
    output logic function_on_out,
    output logic count_gate_out,
    output logic load_settings_out,
    output logic fault_present_out,
    output fpc_pkg::fpc_word_t fault_code_out,
    output fpc_pkg::fpc_word_t act_mode_out,
    output logic signed [CNT_W-1:0] act_high_out,
    output logic signed [CNT_W-1:0] act_low_out,
    output logic signed [CNT_W-1:0] act_ovf_out,
    output logic settings_loaded_out,
    output logic call_req_out,
    output fpc_pkg::fpc_word_t call_file_out,
    output fpc_pkg::fpc_cause_t call_cause_out
);
    import fpc_pkg::*;

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("fpc_ctrl_status: CNT_W out of range");
        end
    end

    // sign-extend a counter value to the bus width
    function automatic logic [31:0] widen(input logic signed [CNT_W-1:0] v);
        widen = 32'(signed'(v));
    endfunction

    fpc_bus_state_t bus_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic acc_wr;
    logic wr_ctrl;

    logic init_done_q;
    logic run_q;
    logic run_rise;
    logic function_on_q;
    logic count_gate_q;
    logic load_settings_q;
    logic load_prev_q;
    logic load_rise;
    logic sub_gate_q;
    logic autostart_q;

    fpc_word_t fault_q;
    fpc_word_t selector_q;
    fpc_word_t mode_q;
    logic signed [CNT_W-1:0] high_q;
    logic signed [CNT_W-1:0] low_q;
    logic signed [CNT_W-1:0] ovf_q;
    logic loaded_q;
    fpc_word_t calls_q;

    fpc_cause_t cause;
    logic call_allow;

    fpc_cfg_if #(.CNT_W(CNT_W)) cfg ();

    // ---- avalon slave: one wait cycle, then answer ----
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_q <= BUS_IDLE;
        end else begin
            unique case (bus_q)
                BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && (bus_q != BUS_ACK);
    assign acc_wr = avs_write_in && (bus_q == BUS_ACK);
    assign wr_ctrl = acc_wr && (avs_address_in == `FPC_OFS_CTRL) && avs_byteenable_in[0];

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address_in)
            `FPC_OFS_CTRL: begin
                rd_d[`FPC_CTRL_FN_ON] = function_on_q;
                rd_d[`FPC_CTRL_AUTOSTART] = autostart_q;
                rd_d[`FPC_CTRL_COUNT_GATE] = count_gate_q;
                rd_d[`FPC_CTRL_LOAD] = load_settings_q;
                rd_d[`FPC_CTRL_SUB_GATE] = sub_gate_q;
                rd_d[`FPC_CTRL_FAULT] = fault_present_out;
                rd_d[`FPC_CTRL_RUN] = run_q;
                rd_d[`FPC_CTRL_COUNTING] = count_enable_out;
            end
            `FPC_OFS_SUBSEL: rd_d = {16'h0000, selector_q};
            `FPC_OFS_FAULT: rd_d = {16'h0000, fault_q};
            `FPC_OFS_MODE: rd_d = {16'h0000, mode_q};
            `FPC_OFS_HIGH: rd_d = widen(high_q);
            `FPC_OFS_LOW: rd_d = widen(low_q);
            `FPC_OFS_OVF: rd_d = widen(ovf_q);
            `FPC_OFS_CALLS: rd_d = {16'h0000, calls_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // read data captured in the wait cycle, stands in the answer cycle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= 32'h0000_0000;
        end else if (avs_read_in && bus_q == BUS_IDLE) begin
            rd_q <= rd_d;
        end
    end

    assign avs_readdata_out = rd_q;

    // ---- retained bits come back from the backup store after reset ----
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    // ---- run or test mode entry ----
    // run entry waits one edge after reset so auto start sees its stored setting
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
        end else if (init_done_q) begin
            run_q <= run_mode_in;
        end
    end

    assign run_rise = run_mode_in && !run_q;

    // auto start is held from stored configuration only, never from the bus
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            autostart_q <= 1'b0;
        end else begin
            autostart_q <= cfg_autostart_in;
        end
    end

    // hardware set from auto start wins over a software clear
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            function_on_q <= 1'b0;
        end else if (run_rise && autostart_q) begin
            function_on_q <= 1'b1;
        end else if (wr_ctrl) begin
            function_on_q <= avs_writedata_in[`FPC_CTRL_FN_ON];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_gate_q <= 1'b0;
        end else if (!init_done_q) begin
            count_gate_q <= ret_count_gate_in;
        end else if (wr_ctrl) begin
            count_gate_q <= avs_writedata_in[`FPC_CTRL_COUNT_GATE];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_settings_q <= 1'b0;
        end else if (!init_done_q) begin
            load_settings_q <= ret_load_settings_in;
        end else if (wr_ctrl) begin
            load_settings_q <= avs_writedata_in[`FPC_CTRL_LOAD];
        end
    end

    // the restored level seeds the edge detector, so power-up is no edge
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_prev_q <= 1'b0;
        end else if (!init_done_q) begin
            load_prev_q <= ret_load_settings_in;
        end else begin
            load_prev_q <= load_settings_q;
        end
    end

    assign load_rise = init_done_q && load_settings_q && !load_prev_q;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sub_gate_q <= 1'b0;
        end else if (wr_ctrl) begin
            sub_gate_q <= avs_writedata_in[`FPC_CTRL_SUB_GATE];
        end
    end

    // ---- check and load of the stored configuration ----
    assign cfg.selector = cfg_selector_in;
    assign cfg.file_present = cfg_file_present_in;
    assign cfg.mode = cfg_mode_in;
    assign cfg.high = cfg_high_in;
    assign cfg.low = cfg_low_in;
    assign cfg.ovf = cfg_ovf_in;

    fpc_cfg_check #(
        .CNT_W(CNT_W)
    ) u_check (
        .cfg(cfg.chk)
    );

    // verdict is always recorded; a faulty set leaves the old settings active
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_q <= `FPC_ERR_NONE;
        end else if (load_rise) begin
            fault_q <= cfg.fault;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            selector_q <= 16'h0000;
            mode_q <= 16'h0000;
            high_q <= '0;
            low_q <= '0;
            ovf_q <= '0;
        end else if (load_rise && cfg.fault == `FPC_ERR_NONE) begin
            selector_q <= cfg_selector_in;
            mode_q <= cfg_mode_in;
            high_q <= cfg_high_in;
            low_q <= cfg_low_in;
            ovf_q <= cfg_ovf_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= load_rise && cfg.fault == `FPC_ERR_NONE;
        end
    end

    assign fault_present_out = fault_q != `FPC_ERR_NONE;
    assign fault_code_out = fault_q;
    assign act_mode_out = mode_q;
    assign act_high_out = high_q;
    assign act_low_out = low_q;
    assign act_ovf_out = ovf_q;
    assign settings_loaded_out = loaded_q;

    // counting depends on the load bit only through the fault verdict at its edge, so a clean load loses no counts
    assign count_enable_out = run_q && function_on_q && count_gate_q
        && !fault_present_out;
    assign function_on_out = function_on_q;
    assign count_gate_out = count_gate_q;
    assign load_settings_out = load_settings_q;

    // ---- subroutine calls ----
    assign cause.lo = lo_preset_hit_in;
    assign cause.hi = hi_preset_hit_in;
    assign cause.ovf = ovf_pass_in;
    assign cause.unf = unf_pass_in;
    assign call_allow = function_on_q && sub_gate_q && run_q
        && !fault_present_out;

    fpc_sub_dispatch u_dispatch (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .cause_in(cause),
        .allow_in(call_allow),
        .file_in(selector_q),
        .call_req_out(call_req_out),
        .call_file_out(call_file_out),
        .call_cause_out(call_cause_out)
    );

    // wrapping count of issued calls, for software diagnostics
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            calls_q <= 16'h0000;
        end else if (call_req_out) begin
            calls_q <= calls_q + 16'h0001;
        end
    end
endmodule // fpc_ctrl_status
`default_nettype wire

// *** dv/fpc_ctrl_status_props.sv ***
// port assertions of the counter control block
`timescale 1ns/10ps
`default_nettype none
module fpc_ctrl_status_props (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic run_mode_in,
    input wire logic cfg_autostart_in,
    input wire logic lo_preset_hit_in,
    input wire logic hi_preset_hit_in,
    input wire logic ovf_pass_in,
    input wire logic unf_pass_in,
    input wire logic count_enable_out,
    input wire logic function_on_out,
    input wire logic count_gate_out,
    input wire logic load_settings_out,
    input wire logic fault_present_out,
    input wire fpc_pkg::fpc_word_t fault_code_out,
    input wire logic settings_loaded_out,
    input wire logic call_req_out
);
    import fpc_pkg::*;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    logic ev;
    assign ev = lo_preset_hit_in | hi_preset_hit_in | ovf_pass_in | unf_pass_in;
    sequence req_s;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence ack_s;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    sequence load_s;
        $past(load_settings_out) && !$past(load_settings_out, 2);
    endsequence
    bus_one_wait_a: assert property (req_s |-> ack_s)
        else $error("bus answer not after one wait cycle");
    fault_flag_a: assert property (fault_present_out == (fault_code_out != 16'h0000))
        else $error("fault flag disagrees with fault code");
    fault_code_range_a: assert property (fault_code_out <= 16'h0004)
        else $error("fault code outside known set");
    count_needs_gate_a: assert property (count_enable_out |-> count_gate_out)
        else $error("counting without count gate");
    count_needs_clean_a: assert property (count_enable_out |-> function_on_out && !fault_present_out)
        else $error("counting while off or faulty");
    call_gated_a: assert property (call_req_out |-> $past(function_on_out) && !$past(fault_present_out))
        else $error("call while function off or faulty");
    call_has_cause_a: assert property (call_req_out |-> $past(ev) && $past(run_mode_in, 2))
        else $error("call without event in run mode");
    auto_start_a: assert property ($rose(run_mode_in) && $past(cfg_autostart_in) |-> ##[1:2] function_on_out)
        else $error("auto start did not set function on");
    fault_on_load_a: assert property ($changed(fault_code_out) |-> load_s)
        else $error("fault code moved without load edge");
    load_done_clean_a: assert property (settings_loaded_out |-> load_s ##0 (fault_code_out == 16'h0000))
        else $error("settings loaded without clean load edge");
endmodule // fpc_ctrl_status_props
bind fpc_ctrl_status fpc_ctrl_status_props fpc_ctrl_status_props_i (.core_clk_in, .rst_in,
    .avs_read_in, .avs_write_in, .avs_waitrequest_out, .run_mode_in, .cfg_autostart_in,
    .lo_preset_hit_in, .hi_preset_hit_in, .ovf_pass_in, .unf_pass_in, .count_enable_out,
    .function_on_out, .count_gate_out, .load_settings_out, .fault_present_out,
    .fault_code_out, .settings_loaded_out, .call_req_out);
`default_nettype wire

// *** dv/fpc_prog_model.sv ***
// control program model: bus master reading and writing the control registers
`timescale 1ns/10ps
`default_nettype none
`include "fpc_params.svh"
module fpc_prog_model (
    input wire logic core_clk_in,
    output logic [`FPC_ADDR_W-1:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [31:0] avs_writedata_out,
    output logic [3:0] avs_byteenable_out,
    input wire logic [31:0] avs_readdata_in,
    input wire logic avs_waitrequest_in
);
    initial begin
        avs_address_out = '0;
        avs_read_out = 1'b0;
        avs_write_out = 1'b0;
        avs_writedata_out = '0;
        avs_byteenable_out = 4'hf;
    end
    // one whole access; the subroutine gate is set or cleared only by such writes, the count gate also by the restore after reset
    task automatic access(input logic wr, input logic [`FPC_ADDR_W-1:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk_in);
        avs_address_out <= a;
        avs_read_out <= !wr;
        avs_write_out <= wr;
        avs_writedata_out <= d;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (avs_waitrequest_in !== 1'b0 && n < 64);
        q = avs_readdata_in;
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        if (n >= 64) begin
            fpc_ctrl_status_tb.num_errors++;
            fpc_ctrl_status_tb.finish_test();
        end
    endtask
endmodule // fpc_prog_model
`default_nettype wire

// *** dv/fpc_ctrl_status_tb.sv ***
// self-checking bench of the counter control block
`timescale 1ns/10ps
`default_nettype none
`include "fpc_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module fpc_ctrl_status_tb;
    import fpc_pkg::*;
    logic core_clk_in, rst_in, run_mode_in, cfg_file_present_in, cfg_autostart_in;
    logic ret_count_gate_in, ret_load_settings_in, avs_read_in, avs_write_in;
    logic avs_waitrequest_out, count_enable_out, function_on_out, fault_present_out;
    logic call_req_out, count_gate_out, load_settings_out;
    logic [3:0] ev, avs_byteenable_in;
    logic [5:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, ctrl, q;
    logic signed [31:0] cfg_high_in, cfg_low_in, cfg_ovf_in, act_high_out, act_low_out, act_ovf_out;
    fpc_word_t cfg_selector_in, cfg_mode_in, fault_code_out, call_file_out, act_mode_out;
    fpc_cause_t call_cause_out;
    int num_errors = 0;
    int comparisons = 0;
    fpc_prog_model fpc_prog_model_i (.core_clk_in, .avs_address_out(avs_address_in),
        .avs_read_out(avs_read_in), .avs_write_out(avs_write_in),
        .avs_writedata_out(avs_writedata_in), .avs_byteenable_out(avs_byteenable_in),
        .avs_readdata_in(avs_readdata_out), .avs_waitrequest_in(avs_waitrequest_out));
    fpc_ctrl_status fpc_ctrl_status_i (.core_clk_in, .rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .run_mode_in, .cfg_selector_in, .cfg_file_present_in,
        .cfg_autostart_in, .cfg_mode_in, .cfg_high_in, .cfg_low_in, .cfg_ovf_in,
        .ret_count_gate_in, .ret_load_settings_in, .lo_preset_hit_in(ev[0]),
        .hi_preset_hit_in(ev[1]), .ovf_pass_in(ev[2]), .unf_pass_in(ev[3]), .count_enable_out,
        .function_on_out, .count_gate_out, .load_settings_out, .fault_present_out,
        .fault_code_out, .act_mode_out, .act_high_out, .act_low_out, .act_ovf_out,
        .settings_loaded_out(), .call_req_out, .call_file_out, .call_cause_out);
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] x;
        fpc_prog_model_i.access(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] x;
        fpc_prog_model_i.access(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask
    task automatic pulse(input logic [3:0] p, input logic e);
        @(posedge core_clk_in);
        ev <= p;
        @(posedge core_clk_in);
        ev <= 4'h0;
        #1;
        `CHK(call_req_out, e)
    endtask
    // offer a candidate setting and make a load edge
    task automatic cfg_case(input fpc_word_t s, input logic p, input fpc_word_t m,
            input logic [31:0] h, input logic [31:0] l, input logic [31:0] o, input fpc_word_t e);
        @(posedge core_clk_in);
        cfg_selector_in <= s;
        cfg_file_present_in <= p;
        cfg_mode_in <= m;
        cfg_high_in <= h;
        cfg_low_in <= l;
        cfg_ovf_in <= o;
        wr(`FPC_OFS_CTRL, ctrl);
        wr(`FPC_OFS_CTRL, ctrl | 32'h8);
        rd(`FPC_OFS_FAULT, {16'h0, e});
        `CHK(fault_present_out, e != 16'h0)
    endtask
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
    endtask
    initial begin
        {rst_in, run_mode_in, cfg_file_present_in, cfg_autostart_in} = 4'h8;
        {ret_count_gate_in, ret_load_settings_in, ev, ctrl} = '0;
        {cfg_selector_in, cfg_mode_in, cfg_high_in, cfg_low_in, cfg_ovf_in} = '0;
        do_reset();
        rd(`FPC_OFS_CTRL, 32'h0);
        wr(`FPC_OFS_CTRL, 32'he2);
        rd(`FPC_OFS_CTRL, 32'h0);
        rd(6'h20, 32'h0);
        cfg_case(16'h2, 1, 0, 10, 0, 20, `FPC_ERR_FILE);
        cfg_case(16'h100, 1, 0, 10, 0, 20, `FPC_ERR_FILE);
        cfg_case(16'h3, 0, 0, 10, 0, 20, `FPC_ERR_FILE);
        cfg_case(16'h3, 1, 8, 10, 0, 20, `FPC_ERR_MODE);
        cfg_case(16'h3, 1, 0, 0, 0, 20, `FPC_ERR_HIGH);
        cfg_case(16'h3, 1, 1, 32'hffffffff, 0, 20, `FPC_ERR_HIGH);
        cfg_case(16'h3, 1, 2, 5, 5, 20, `FPC_ERR_HIGH);
        cfg_case(16'h3, 1, 7, 5, 2, 4, `FPC_ERR_OVF);
        cfg_case(16'h3, 1, 0, 21, 0, 20, `FPC_ERR_OVF);
        cfg_case(16'hff, 1, 3, 20, 2, 20, `FPC_ERR_NONE);
        rd(`FPC_OFS_SUBSEL, 32'hff);
        rd(`FPC_OFS_HIGH, 32'd20);
        rd(`FPC_OFS_LOW, 32'd2);
        `CHK(act_mode_out, 16'h0003)
        `CHK(act_high_out, 32'sd20)
        `CHK(act_low_out, 32'sd2)
        `CHK(act_ovf_out, 32'sd20)
        run_mode_in <= 1'b1;
        wr(`FPC_OFS_CTRL, 32'h15);
        #1;
        `CHK(count_enable_out, 1'b1)
        wr(`FPC_OFS_CTRL, 32'h11);
        #1;
        `CHK(count_enable_out, 1'b0)
        wr(`FPC_OFS_CTRL, 32'h1d);
        #1;
        `CHK(count_enable_out, 1'b1)
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i, 1'b1);
            `CHK(call_cause_out, fpc_cause_t'(4'h1 << i))
            `CHK(call_file_out, 16'h00ff)
        end
        wr(`FPC_OFS_CTRL, 32'h05);
        pulse(4'h2, 1'b0);
        wr(`FPC_OFS_CTRL, 32'h14);
        pulse(4'h2, 1'b0);
        rd(`FPC_OFS_CALLS, 32'h4);
        cfg_autostart_in <= 1'b1;
        run_mode_in <= 1'b0;
        wr(`FPC_OFS_CTRL, 32'h10);
        run_mode_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        `CHK(function_on_out, 1'b1)
        `CHK(count_enable_out, 1'b0)
        rd(`FPC_OFS_CTRL, 32'h53);
        {cfg_autostart_in, run_mode_in, ret_count_gate_in, ret_load_settings_in} <= 4'h3;
        do_reset();
        rd(`FPC_OFS_CTRL, 32'h0c);
        rd(`FPC_OFS_FAULT, 32'h0);
        `CHK(count_gate_out, 1'b1)
        `CHK(load_settings_out, 1'b1)
        finish_test();
    end
endmodule // fpc_ctrl_status_tb
`default_nettype wire
